//--- logic/lcd_blink_ctrl.sv
// segment lcd blank, blink and dual display memory control with register port
// assumes FRAME_END pulses after the last common phase and LCD_TICK at f_lcd,
// both from logic on SYS_CLK; PUMP_QUIET_REQ arrives from outside the domain
`default_nettype none
module lcd_blink_ctrl #(
  parameter int MEM_BYTES = 20
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic BUS_WORD,
  output logic [15:0] BUS_RDATA,
  input wire logic LCD_TICK,
  input wire logic FRAME_END,
  input wire logic PUMP_QUIET_REQ,
  output logic [8*MEM_BYTES-1:0] SEG_OUT,
  output logic VLCD_FROM_SUPPLY,
  output logic VLCD_FROM_PUMP,
  output logic PUMP_RUN,
  output logic VLCD_ON_CAP
);
  import lcd_blink_pkg::*;

  // word access pairs bytes, and the index is five bits wide
  if (MEM_BYTES < 2 || MEM_BYTES > 32 || (MEM_BYTES % 2) != 0) begin : g_size_chk
    $error("MEM_BYTES must be even and 2 to 32");
  end

  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] dm;
    logic [MEM_BYTES-1:0][7:0] bm;
    logic son;
    logic [2:0] mux;
    logic [1:0] mode;
    logic [2:0] pre;
    logic disp_req;
    logic disp_active;
    logic blank;
    logic clr;
    logic supply;
    logic ref_en;
    logic pump_en;
    logic auto_quiet;
    logic [3:0] vsel;
    logic quiet_s1;
    logic quiet_s2;
    logic [15:0] rdata;
    logic [8*MEM_BYTES-1:0] seg;
    logic from_supply;
    logic from_pump;
    logic pump_run;
    logic on_cap;
  } ctrl_state_t;

  ctrl_state_t r;
  ctrl_state_t n;

  logic [1:0] eff_mode;
  logic second_half;
  logic frame_go;
  logic next_disp;
  logic next_blank;
  logic [8*MEM_BYTES-1:0] pattern;
  logic dm_hit;
  logic bm_hit;
  logic [7:0] dm_idx;
  logic [7:0] bm_idx;
  logic bm_word;

  // blinking only where the mux rate serves the chosen mode
  always_comb begin
    if (r.mux >= MUX_HIGH_FIRST) begin
      eff_mode = (r.mode == MODE_ALL) ? MODE_ALL : MODE_OFF;
    end else begin
      eff_mode = r.mode;
    end
  end

  lcd_blink_divider #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clk_en(CLK_EN),
    .hold(eff_mode == MODE_OFF),
    .lcd_tick(LCD_TICK),
    .mux_rate(r.mux),
    .prescaler(r.pre),
    .second_half(second_half)
  );

  assign frame_go = FRAME_END;

  // memory picked for the coming frame
  always_comb begin
    unique case (eff_mode)
      MODE_OFF: next_disp = r.disp_req;
      MODE_SWAP: next_disp = second_half;
      MODE_SEG, MODE_ALL: next_disp = 1'b0;
    endcase
  end

  // first half of each blink period is the dark one
  assign next_blank = (eff_mode == MODE_SEG || eff_mode == MODE_ALL) && !second_half;

  genvar gi;
  generate
    for (gi = 0; gi < MEM_BYTES; gi++) begin : g_seg
      logic [7:0] src;
      logic [7:0] dark;
      assign src = next_disp ? r.bm[gi] : r.dm[gi];
      // mode 10 uses no blink memory bit at all
      assign dark = !next_blank ? 8'h00 :
                    (eff_mode == MODE_SEG) ? r.bm[gi] : 8'hff;
      assign pattern[8*gi +: 8] = {8{r.son}} & src & ~dark;
    end
  endgenerate

  assign dm_hit = BUS_ADDR >= ADDR_DM_BASE && BUS_ADDR < ADDR_DM_BASE + 8'(MEM_BYTES);
  assign bm_hit = BUS_ADDR >= ADDR_BM_BASE && BUS_ADDR < ADDR_BM_BASE + 8'(MEM_BYTES);
  assign dm_idx = BUS_ADDR - ADDR_DM_BASE;
  assign bm_idx = BUS_ADDR - ADDR_BM_BASE;
  // word access to blink memory only at even addresses
  assign bm_word = bm_hit && BUS_WORD && !bm_idx[0];

  always_comb begin
    n = r;
    n.rdata = 16'h0000;
    if (BUS_WR) begin
      if (BUS_ADDR == ADDR_CTL) begin
        n.son = BUS_WDATA[CTL_SON_BIT];
        n.mux = BUS_WDATA[CTL_MUX_LSB +: 3];
      end
      if (BUS_ADDR == ADDR_BLINK) begin
        n.mode = BUS_WDATA[BLK_MODE_LSB +: 2];
        n.pre = BUS_WDATA[BLK_PRE_LSB +: 3];
      end
      if (BUS_ADDR == ADDR_MEMCTL) begin
        n.disp_req = BUS_WDATA[MEM_DISP_BIT];
        n.clr = r.clr | BUS_WDATA[MEM_CLR_BIT];
      end
      if (BUS_ADDR == ADDR_VCTL) begin
        n.supply = BUS_WDATA[V_SUPPLY_BIT];
        n.ref_en = BUS_WDATA[V_REF_BIT];
        n.pump_en = BUS_WDATA[V_PUMP_BIT];
        n.auto_quiet = BUS_WDATA[V_AUTO_BIT];
        n.vsel = BUS_WDATA[V_SEL_LSB +: 4];
      end
      if (dm_hit) begin
        n.dm[dm_idx[4:0]] = BUS_WDATA[7:0];
      end
      if (bm_hit) begin
        n.bm[bm_idx[4:0]] = BUS_WDATA[7:0];
      end
      if (bm_word) begin
        n.bm[bm_idx[4:0] + 5'h01] = BUS_WDATA[15:8];
      end
    end
    if (BUS_RD) begin
      if (BUS_ADDR == ADDR_CTL) begin
        n.rdata = 16'(r.son) | (16'(r.mux) << CTL_MUX_LSB);
      end
      if (BUS_ADDR == ADDR_BLINK) begin
        n.rdata = (16'(r.mode) << BLK_MODE_LSB) | (16'(r.pre) << BLK_PRE_LSB);
      end
      if (BUS_ADDR == ADDR_MEMCTL) begin
        // in mode 11 below mux code 4 the select bit reports the memory on the glass
        n.rdata = 16'((eff_mode == MODE_SWAP) ? r.disp_active : r.disp_req)
                  | (16'(r.clr) << MEM_CLR_BIT);
      end
      if (BUS_ADDR == ADDR_VCTL) begin
        n.rdata = 16'({r.vsel, r.auto_quiet, r.pump_en, r.ref_en, r.supply});
      end
      if (dm_hit) begin
        n.rdata = 16'(r.dm[dm_idx[4:0]]);
      end
      if (bm_hit) begin
        n.rdata = 16'(r.bm[bm_idx[4:0]]);
      end
      if (bm_word) begin
        n.rdata = {r.bm[bm_idx[4:0] + 5'h01], r.bm[bm_idx[4:0]]};
      end
    end
    if (frame_go) begin
      n.disp_active = next_disp;
      n.blank = next_blank;
      n.seg = pattern;
      if (r.clr) begin
        n.bm = '0;
        // a new request in the same cycle keeps the bit set
        n.clr = BUS_WR && BUS_ADDR == ADDR_MEMCTL && BUS_WDATA[MEM_CLR_BIT];
      end
    end
    // quiet request passes two flops before anything reads it
    n.quiet_s1 = PUMP_QUIET_REQ;
    n.quiet_s2 = r.quiet_s1;
    n.from_supply = r.supply && !r.ref_en;
    n.from_pump = !r.supply && r.pump_en;
    n.pump_run = !r.supply && r.pump_en && !(r.auto_quiet && r.quiet_s2);
    // pump paused with a voltage level set: capacitor keeps vlcd up
    n.on_cap = !r.supply && r.vsel != 4'h0
               && !(r.pump_en && !(r.auto_quiet && r.quiet_s2));
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      r <= '0;
      r.mux <= MUX_RESET;
      r.pre <= PRE_RESET;
      r.vsel <= VSEL_RESET;
    end else if (CLK_EN) begin
      r <= n;
    end
  end

  assign BUS_RDATA = r.rdata;
  assign SEG_OUT = r.seg;
  assign VLCD_FROM_SUPPLY = r.from_supply;
  assign VLCD_FROM_PUMP = r.from_pump;
  assign PUMP_RUN = r.pump_run;
  assign VLCD_ON_CAP = r.on_cap;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_blank_all;
    (CLK_EN && FRAME_END && !r.son) |=> SEG_OUT == '0;
  endproperty
  a_blank_all: assert property (p_blank_all) else $error("segments lit while blanked");

  property p_all_dark;
    (CLK_EN && FRAME_END && eff_mode == MODE_ALL && !second_half) |=> SEG_OUT == '0;
  endproperty
  a_all_dark: assert property (p_all_dark) else $error("blink-all half not dark");

  property p_high_mux;
    (r.mux >= MUX_HIGH_FIRST && r.mode != MODE_ALL) |-> eff_mode == MODE_OFF;
  endproperty
  a_high_mux: assert property (p_high_mux) else $error("blink active at high mux");

  property p_clear;
    (CLK_EN && FRAME_END && r.clr) |=> (r.bm == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("blink memory not cleared");

  property p_clear_wait;
    (CLK_EN && !FRAME_END && r.clr) |=> r.clr;
  endproperty
  a_clear_wait: assert property (p_clear_wait) else $error("clear bit dropped early");

  property p_div_off;
    (CLK_EN && eff_mode == MODE_OFF) |=> !second_half;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider runs in mode 00");

  property p_manual_sel;
    (CLK_EN && FRAME_END && eff_mode == MODE_OFF) |=> r.disp_active == $past(r.disp_req);
  endproperty
  a_manual_sel: assert property (p_manual_sel) else $error("manual select missed");

  property p_swap_sel;
    (CLK_EN && FRAME_END && eff_mode == MODE_SWAP) |=> r.disp_active == $past(second_half);
  endproperty
  a_swap_sel: assert property (p_swap_sel) else $error("swap memory wrong");

  property p_frame_only;
    !(CLK_EN && FRAME_END) |=> ($stable(SEG_OUT) && $stable(r.disp_active));
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("display moved between frames");

  property p_supply;
    (CLK_EN && r.supply && !r.ref_en) |=> VLCD_FROM_SUPPLY && !VLCD_FROM_PUMP;
  endproperty
  a_supply: assert property (p_supply) else $error("supply source wrong");

  property p_pump_stop;
    (CLK_EN && !r.pump_en && r.vsel != 4'h0 && !r.supply) |=> !PUMP_RUN && VLCD_ON_CAP;
  endproperty
  a_pump_stop: assert property (p_pump_stop) else $error("pump not stopped");

  property p_read_once;
    (CLK_EN && !BUS_RD) |=> BUS_RDATA == 16'h0000;
  endproperty
  a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

  c_swap: cover property (CLK_EN && FRAME_END && eff_mode == MODE_SWAP && second_half);
  c_seg_blink: cover property (CLK_EN && FRAME_END && eff_mode == MODE_SEG && !second_half);
  c_clear: cover property (CLK_EN && FRAME_END && r.clr);
  c_word: cover property (CLK_EN && BUS_WR && bm_word);
endmodule : lcd_blink_ctrl
`default_nettype wire

//--- logic/lcd_blink_divider.sv
// blink clock divider: half period is (mux + 1) * 2^(prescaler + 1) lcd ticks
// assumes lcd_tick is a one-cycle enable on the same clock
`default_nettype none
module lcd_blink_divider #(
  parameter int CNT_W = lcd_blink_pkg::DIV_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hold,
  input wire logic lcd_tick,
  input wire logic [2:0] mux_rate,
  input wire logic [2:0] prescaler,
  output logic second_half
);
  import lcd_blink_pkg::*;

  // refused at elaboration: the longest half period would wrap the counter
  if (CNT_W < DIV_CNT_W) begin : g_width_chk
    $error("divider counter too narrow");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic second;
  } div_state_t;

  div_state_t r;
  div_state_t n;
  logic [CNT_W-1:0] half_len;

  // full period (mux+1)*2^(pre+2), so each half is (mux+1)*2^(pre+1)
  // shift amount kept at four bits so prescaler 7 does not wrap to zero
  assign half_len = CNT_W'((CNT_W'(mux_rate) + CNT_W'(1)) << (4'(prescaler) + 4'h1));

  always_comb begin
    n = r;
    if (hold) begin
      n.cnt = '0;
      n.second = 1'b0;
    end else if (lcd_tick) begin
      if (r.cnt >= half_len - CNT_W'(1)) begin
        n.cnt = '0;
        n.second = ~r.second;
      end else begin
        n.cnt = r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign second_half = r.second;

  property p_div_hold;
    @(posedge clk) disable iff (!rst_n)
    (clk_en && hold) |=> (r.cnt == '0 && !second_half);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider not held in reset");
endmodule : lcd_blink_divider
`default_nettype wire

//--- shared/lcd_blink_pkg.sv
// constants for the segment lcd blink, blank and dual memory block
// assumes byte addressed register port, mux rate codes 0 (static) to 7 (8-mux)
`default_nettype none
package lcd_blink_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_BLINK = 8'h01;
  localparam logic [7:0] ADDR_MEMCTL = 8'h02;
  localparam logic [7:0] ADDR_VCTL = 8'h03;
  localparam logic [7:0] ADDR_DM_BASE = 8'h20;
  localparam logic [7:0] ADDR_BM_BASE = 8'h40;
  // ctl fields
  localparam int CTL_SON_BIT = 0;
  localparam int CTL_MUX_LSB = 2;
  // blink fields
  localparam int BLK_MODE_LSB = 0;
  localparam int BLK_PRE_LSB = 2;
  // memctl fields
  localparam int MEM_DISP_BIT = 0;
  localparam int MEM_CLR_BIT = 1;
  // vctl fields
  localparam int V_SUPPLY_BIT = 0;
  localparam int V_REF_BIT = 1;
  localparam int V_PUMP_BIT = 2;
  localparam int V_AUTO_BIT = 3;
  localparam int V_SEL_LSB = 4;
  // blink mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SEG = 2'h1;
  localparam logic [1:0] MODE_ALL = 2'h2;
  localparam logic [1:0] MODE_SWAP = 2'h3;
  // mux code from which only blink-all is served (5-mux)
  localparam logic [2:0] MUX_HIGH_FIRST = 3'h4;
  // values after reset
  localparam logic [2:0] MUX_RESET = 3'h0;
  localparam logic [2:0] PRE_RESET = 3'h0;
  localparam logic [3:0] VSEL_RESET = 4'h0;
  // divider counter width: largest half period is 8 * 2^8 lcd ticks
  localparam int DIV_CNT_W = 12;
endpackage : lcd_blink_pkg
`default_nettype wire

//--- testbench/lcd_blink_ctrl_tb_top.sv
// self-checking bench for the lcd blink, blank and dual memory controller
// assumes the panel model drives lcd tick and frame end on the same clock
`default_nettype none
module lcd_blink_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_blink_pkg::*;
  localparam int MB = 4;
  localparam int FT = 2;
  logic clk, rst_n, en, wr_s, rd_s, wrd, quiet, tick, fe, fs, vs, vp, pr, vc, rd_q;
  logic [7:0] a;
  logic [15:0] wd, rdat;
  logic [8*MB-1:0] seg, shown;
  logic [15:0] rq[$];
  int fqn[$];
  logic [31:0] fqv[$];
  logic [31:0] dm, bm, cur;
  int miscompares = 0;
  int cmp_count = 0;
  int fcount = 0;

  lcd_blink_ctrl #(.MEM_BYTES(MB)) lcd_blink_ctrl_i (
    .SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(en), .BUS_ADDR(a), .BUS_WDATA(wd), .BUS_WR(wr_s),
    .BUS_RD(rd_s), .BUS_WORD(wrd), .BUS_RDATA(rdat), .LCD_TICK(tick), .FRAME_END(fe),
    .PUMP_QUIET_REQ(quiet), .SEG_OUT(seg), .VLCD_FROM_SUPPLY(vs), .VLCD_FROM_PUMP(vp),
    .PUMP_RUN(pr), .VLCD_ON_CAP(vc)
  );
  lcd_panel_model #(.FRAME_TICKS(FT), .W(8*MB)) lcd_panel_model_i (
    .clk(clk), .rst_n(rst_n), .seg(seg), .lcd_tick(tick), .frame_end(fe), .frame_seen(fs),
    .shown(shown)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic w = 1'b0);
    @(posedge clk);
    wr_s <= 1'b1;
    a <= ad;
    wd <= d;
    wrd <= w;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [15:0] e, input logic w = 1'b0);
    @(posedge clk);
    rd_s <= 1'b1;
    a <= ad;
    wrd <= w;
    rq.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd

  task automatic note(input int n, input logic [31:0] e);
    fqn.push_back(n);
    fqv.push_back(e);
  endtask : note

  task automatic sync;
    @(posedge clk iff fs);
    #1;
  endtask : sync

  task automatic upto(input int t);
    for (int i = 0; i < 2000 && fcount < t; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : upto

  // one register write right after a frame, display checked the frame after
  task automatic step(input logic [7:0] ad, input logic [15:0] d, input logic [31:0] e);
    int b;
    sync();
    b = fcount;
    wr(ad, d);
    chk(seg, cur);
    note(b + 1, e);
    cur = e;
    upto(b + 1);
  endtask : step

  // frames are sampled well inside each half period so divider phase does not matter
  task automatic blink(input logic [2:0] mx, input logic [2:0] pre, input logic [1:0] md,
                       input logic [31:0] dk, input logic [31:0] lit, input logic sw);
    int hf;
    int b;
    hf = ((int'(mx) + 1) << (int'(pre) + 1)) / FT;
    wr(ADDR_CTL, 16'({mx, 2'h1}));
    wr(ADDR_BLINK, 16'({pre, MODE_OFF}));
    sync();
    b = fcount;
    wr(ADDR_BLINK, 16'({pre, md}));
    note(b + 1, dk);
    note(b + hf / 2, dk);
    note(b + hf + hf / 2, lit);
    note(b + 2 * hf + hf / 2, dk);
    upto(b + hf + hf / 2);
    if (sw) rd(ADDR_MEMCTL, 16'h1);
    upto(b + 2 * hf + hf / 2 + 1);
    wr(ADDR_BLINK, 16'({pre, MODE_OFF}));
    wr(ADDR_CTL, 16'h1);
    cur = dm;
    $display("blink test mux %0d mode %0d done", mx, md);
  endtask : blink

  always @(posedge clk) begin
    if (rd_q && rq.size() > 0) chk({16'h0, rdat}, {16'h0, rq.pop_front()});
    rd_q <= rd_s && en;
  end

  always @(posedge clk) begin
    if (fs) begin
      fcount++;
      if (fqn.size() > 0 && fqn[0] == fcount) begin
        void'(fqn.pop_front());
        chk(shown, fqv.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    int b;
    logic [7:0] v;
    logic q;
    logic run;
    {rst_n, en, wr_s, rd_s, wrd, quiet, rd_q, a, wd} = '0;
    cur = '0;
    void'($urandom(32'h2f8858e7));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'(i), 16'h0);
    rd(8'h10, 16'h0);
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0);
    en <= 1'b0;
    wr(ADDR_CTL, 16'h1d);
    en <= 1'b1;
    rd(ADDR_CTL, 16'h0);
    $display("register test done");
    dm = $urandom();
    bm = $urandom();
    dm[7:0] = 8'h02;
    bm[7:0] = 8'h02;
    for (int i = 0; i < MB; i++) wr(ADDR_DM_BASE + 8'(i), 16'(dm[8*i +: 8]));
    for (int i = 0; i < MB; i += 2) wr(ADDR_BM_BASE + 8'(i), bm[8*i +: 16], 1'b1);
    rd(ADDR_BM_BASE + 8'h2, bm[31:16], 1'b1);
    rd(ADDR_BM_BASE + 8'h3, 16'(bm[31:24]));
    rd(ADDR_DM_BASE + 8'h2, 16'(dm[23:16]), 1'b1);
    step(ADDR_MEMCTL, 16'h0, 32'h0);
    step(ADDR_CTL, 16'h1, dm);
    step(ADDR_MEMCTL, 16'h1, bm);
    step(ADDR_MEMCTL, 16'h0, dm);
    step(ADDR_CTL, 16'h0, 32'h0);
    step(ADDR_CTL, 16'h1, dm);
    $display("dual memory test done");
    blink(3'h0, 3'h3, MODE_ALL, 32'h0, dm, 1'b0);
    blink(3'h0, 3'h7, MODE_ALL, 32'h0, dm, 1'b0);
    wr(ADDR_BM_BASE, 16'h0);
    bm[7:0] = 8'h00;
    blink(3'h0, 3'h3, MODE_SEG, dm & ~bm, dm, 1'b0);
    wr(ADDR_BM_BASE, 16'h2);
    bm[7:0] = 8'h02;
    blink(3'h0, 3'h3, MODE_SWAP, dm, bm, 1'b1);
    step(ADDR_MEMCTL, 16'h0, dm);
    blink(MUX_HIGH_FIRST, 3'h0, MODE_SEG, dm, dm, 1'b0);
    blink(MUX_HIGH_FIRST, 3'h0, MODE_ALL, 32'h0, dm, 1'b0);
    sync();
    b = fcount;
    wr(ADDR_MEMCTL, 16'h2);
    rd(ADDR_MEMCTL, 16'h2);
    upto(b + 1);
    rd(ADDR_BM_BASE, 16'h0, 1'b1);
    rd(ADDR_BM_BASE + 8'h2, 16'h0, 1'b1);
    rd(ADDR_MEMCTL, 16'h0);
    $display("blink memory clear test done");
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom());
      q = 1'($urandom());
      quiet <= q;
      wr(ADDR_VCTL, 16'(v));
      repeat (4) @(posedge clk);
      run = ~v[0] & v[2] & ~(v[3] & q);
      chk(32'({vs, vp, pr, vc}), 32'({v[0] & ~v[1], ~v[0] & v[2], run,
          ~v[0] & (v[7:4] != 4'h0) & ~run}));
    end
    $display("lcd voltage test done");
    repeat (4) @(posedge clk);
    chk(32'(fqn.size() + rq.size()), 32'h0);
    end_sim();
  end
endmodule : lcd_blink_ctrl_tb_top
`default_nettype wire

//--- testbench/lcd_panel_model.sv
// panel side model: lcd tick and frame timing, latches the pattern each frame shows
// assumes one clock shared with the controller, synchronous active low reset
`default_nettype none
module lcd_panel_model #(
  parameter int TICK_DIV = 4,
  parameter int FRAME_TICKS = 2,
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] seg,
  output logic lcd_tick,
  output logic frame_end,
  output logic frame_seen,
  output logic [W-1:0] shown
);
  timeunit 1ns;
  timeprecision 1ps;
  int div;
  int ticks;
  logic fe1;
  // frames kept short so any blink setting used stays slower than the frame rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div <= 0;
      ticks <= 0;
      lcd_tick <= 1'b0;
      frame_end <= 1'b0;
      fe1 <= 1'b0;
      frame_seen <= 1'b0;
      shown <= '0;
    end else begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      lcd_tick <= (div == TICK_DIV - 1);
      if (lcd_tick) begin
        ticks <= (ticks == FRAME_TICKS - 1) ? 0 : ticks + 1;
      end
      // pulse once the last common phase of the frame is over
      frame_end <= lcd_tick && ticks == FRAME_TICKS - 1;
      fe1 <= frame_end;
      frame_seen <= fe1;
      // segment lines settle the cycle after the frame end
      if (fe1) begin
        shown <= seg;
      end
    end
  end
endmodule : lcd_panel_model
`default_nettype wire
